// >>> spc_pkg.sv
// How it works
// - Transmit-empty request needs transmit interrupt enable.
// - Receive interrupt enable gates receive-full and error requests.
// - Transmitter runs only while transmit enabled.
// - Receiver runs only while receive enabled.
// - Address filter only in async multiprocessor mode.
// - Filter discards characters with multiprocessor bit 0.
// - Filter suppresses receive-full, framing, overrun flags.
// - Marked character clears filter, normal reception resumes.
// - Transmit-done request needs its enable bit.
// - Async code 00: internal clock, pin idle.
// - Async code 01: internal clock, bit clock out.
// - Async code 10: external 16x clock in.
// - Sync code 00: internal clock driven out.
// - Sync code 10: pin is external clock input.
// - Mode bit picks async or clocked synchronous.
// - Multiprocessor mode ignores parity settings.
`default_nettype none
package spc_pkg;
  localparam logic [7:0] SPC_OFS_CTRL = 8'h00;
  localparam logic [7:0] SPC_OFS_FORMAT = 8'h04;
  localparam logic [7:0] SPC_OFS_LINE = 8'h08;
  localparam logic [7:0] SPC_OFS_EVENT = 8'h0c;
  localparam logic [7:0] SPC_OFS_MASK = 8'h10;
  localparam logic [7:0] SPC_RST_CTRL = 8'h00;
  localparam logic [7:0] SPC_RST_FORMAT = 8'h00;
  localparam logic [3:0] SPC_RST_MASK = 4'h0;
  // Control register fields.
  localparam int SPC_B_TX_EMPTY_IE = 7;
  localparam int SPC_B_RX_IE = 6;
  localparam int SPC_B_TX_EN = 5;
  localparam int SPC_B_RX_EN = 4;
  localparam int SPC_B_FILTER = 3;
  localparam int SPC_B_TX_DONE_IE = 2;
  localparam int SPC_B_CLK_HI = 1;
  localparam int SPC_B_CLK_LO = 0;
  // Format register fields.
  localparam int SPC_B_SYNC = 7;
  localparam int SPC_B_CHAR7 = 6;
  localparam int SPC_B_PAR_EN = 5;
  localparam int SPC_B_PAR_ODD = 4;
  localparam int SPC_B_STOP2 = 3;
  localparam int SPC_B_MULTI = 2;
  // Line status fields.
  localparam int SPC_B_RX_FULL = 0;
  localparam int SPC_B_FRAME_ERR = 1;
  localparam int SPC_B_OVERRUN = 2;
  // Event fields.
  localparam int SPC_E_RX = 0;
  localparam int SPC_E_ERR = 1;
  localparam int SPC_E_TX_DONE = 2;
  localparam int SPC_E_MATCH = 3;
  localparam int SPC_OVERSAMPLE = 16;
  localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SPC_CLK_INT = 2'b00,
    SPC_CLK_INT_OUT = 2'b01,
    SPC_CLK_EXT = 2'b10,
    SPC_CLK_RSVD = 2'b11
  } spc_clk_sel_t;
endpackage
`default_nettype wire

// >>> spc_clk_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spc_clk_if;
  import spc_pkg::*;
  logic sync_mode;
  spc_clk_sel_t sel;
  logic bit_tick;
  logic ext_clk;
  modport ctrl (output sync_mode, output sel, input bit_tick, input ext_clk);
  modport gen (input sync_mode, input sel, output bit_tick, output ext_clk);
endinterface
`default_nettype wire

// >>> spc_clk_gen.sv
`timescale 1ns/100ps
`default_nettype none
module spc_clk_gen
  import spc_pkg::*;
#(
  parameter int OVERSAMPLE = SPC_OVERSAMPLE
) (
  input wire logic clk,
  input wire logic nrst,
  spc_clk_if.gen cif,
  input wire logic baud_half_tick,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe
);
  localparam int CW = $clog2(OVERSAMPLE);

  initial begin
    if (OVERSAMPLE < 2) begin
      $error("spc_clk_gen: OVERSAMPLE must be at least 2");
    end
  end

  logic pin_q, pin_out, half_q;
  logic next_pin_q, next_pin_out, next_half_q;
  logic [CW-1:0] cnt, next_cnt;
  logic ext_rise;

  assign ext_rise = pin_i & ~pin_q;
  assign cif.ext_clk = (cif.sel == SPC_CLK_EXT);

  // ==========================================================
  // Clock source selection
  always_comb begin
    next_pin_q = pin_i;
    next_pin_out = pin_out;
    next_half_q = half_q;
    next_cnt = cnt;
    cif.bit_tick = 1'b0;
    pin_oe = 1'b0;
    if (cif.sel == SPC_CLK_EXT) begin
      if (cif.sync_mode) begin
        cif.bit_tick = ext_rise;
      end else if (ext_rise) begin
        next_cnt = (cnt == CW'(OVERSAMPLE - 1)) ? '0 : cnt + 1'b1;
        cif.bit_tick = (cnt == CW'(OVERSAMPLE - 1));
      end
    end else if (cif.sel != SPC_CLK_RSVD) begin
      if (baud_half_tick) begin
        next_half_q = ~half_q;
        next_pin_out = ~pin_out;
        cif.bit_tick = half_q;
      end
      // Sync mode drives only code 00; async drives only code 01.
      pin_oe = cif.sync_mode ? (cif.sel == SPC_CLK_INT)
                             : (cif.sel == SPC_CLK_INT_OUT);
    end
    if (cif.sel != SPC_CLK_EXT) begin
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b1;
      pin_out <= 1'b1;
      half_q <= 1'b0;
      cnt <= '0;
    end else begin
      pin_q <= next_pin_q;
      pin_out <= next_pin_out;
      half_q <= next_half_q;
      cnt <= next_cnt;
    end
  end

  assign pin_o = pin_out;

  a_ext_no_drive: assert property (@(posedge clk) disable iff (!nrst)
    (cif.sel == SPC_CLK_EXT) |-> !pin_oe)
    else $error("pin driven while external clock selected");
  a_async_pin_idle: assert property (@(posedge clk) disable iff (!nrst)
    (!cif.sync_mode && cif.sel == SPC_CLK_INT) |-> !pin_oe)
    else $error("pin driven in async code 00");
endmodule
`default_nettype wire

// >>> spc_serial_control.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module spc_serial_control
  import spc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_char_valid,
  input wire logic rx_char_mpb,
  input wire logic rx_char_frame_err,
  input wire logic rx_char_overrun,
  input wire logic tx_empty,
  input wire logic tx_done,
  input wire logic baud_half_tick,
  input wire logic serial_clk_pin_i,
  output logic serial_clk_pin_o,
  output logic serial_clk_pin_oe,
  output logic bit_tick,
  output logic ext_clk_sel,
  output logic tx_run,
  output logic rx_run,
  output logic rx_char_accept,
  output logic sync_mode,
  output logic char7,
  output logic parity_en,
  output logic parity_odd,
  output logic two_stop,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_done_irq,
  output logic irq
);
  initial begin
    if (ADDR_W < 8) begin
      $error("spc_serial_control: ADDR_W too small for the register map");
    end
  end

  function automatic logic [7:0] spc_ofs(input logic [ADDR_W-1:0] a);
    spc_ofs = {a[7:2], 2'b00};
  endfunction

  logic [7:0] serial_control, serial_format, next_control, next_format;
  logic [2:0] serial_status, next_status;
  logic [3:0] events, next_events, mask, next_mask;
  logic aw_full, w_full, next_aw_full, next_w_full;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [7:0] w_data, next_w_data;
  logic w_lane, next_w_lane;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic accept_q, next_accept_q, tx_done_q, next_tx_done_q;
  logic do_write, do_read, filter_active, rx_take, rx_drop, rx_release;
  logic rx_ok;

  spc_clk_if cif ();

  spc_clk_gen #(.OVERSAMPLE(SPC_OVERSAMPLE)) u_clk (
    .clk(clk),
    .nrst(nrst),
    .cif(cif.gen),
    .baud_half_tick(baud_half_tick),
    .pin_i(serial_clk_pin_i),
    .pin_o(serial_clk_pin_o),
    .pin_oe(serial_clk_pin_oe)
  );

  assign cif.sync_mode = serial_format[SPC_B_SYNC];
  assign cif.sel = spc_clk_sel_t'({serial_control[SPC_B_CLK_HI], serial_control[SPC_B_CLK_LO]});
  assign bit_tick = cif.bit_tick;
  assign ext_clk_sel = cif.ext_clk;

  // ==========================================================
  // Bus handshakes
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign do_write = aw_full && w_full && !bvalid;
  assign do_read = s_axi_arvalid && !rvalid;

  // ==========================================================
  // Receive path and filter
  assign tx_run = serial_control[SPC_B_TX_EN];
  assign rx_run = serial_control[SPC_B_RX_EN];
  assign filter_active = serial_control[SPC_B_FILTER] && serial_format[SPC_B_MULTI]
                         && !serial_format[SPC_B_SYNC];
  assign rx_take = rx_char_valid && rx_run;
  assign rx_drop = rx_take && filter_active && !rx_char_mpb;
  assign rx_release = rx_take && filter_active && rx_char_mpb;
  assign rx_ok = rx_take && !rx_drop;
  assign rx_char_accept = accept_q;

  assign sync_mode = serial_format[SPC_B_SYNC];
  assign char7 = serial_format[SPC_B_CHAR7];
  assign parity_en = serial_format[SPC_B_PAR_EN] && !serial_format[SPC_B_MULTI];
  assign parity_odd = serial_format[SPC_B_PAR_ODD] && parity_en;
  assign two_stop = serial_format[SPC_B_STOP2];

  assign tx_empty_irq = serial_control[SPC_B_TX_EMPTY_IE] && tx_empty;
  assign rx_full_irq = serial_control[SPC_B_RX_IE] && serial_status[SPC_B_RX_FULL];
  assign rx_error_irq = serial_control[SPC_B_RX_IE]
                        && (serial_status[SPC_B_FRAME_ERR] || serial_status[SPC_B_OVERRUN]);
  assign tx_done_irq = serial_control[SPC_B_TX_DONE_IE] && tx_done;
  assign irq = |(events & mask);

  // ==========================================================
  // Register file
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_control = serial_control;
    next_format = serial_format;
    next_status = serial_status;
    next_events = events;
    next_mask = mask;
    next_accept_q = rx_ok && !rx_char_frame_err;
    next_tx_done_q = tx_done;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp = SPC_RESP_OKAY;
      next_rdata = '0;
      unique case (spc_ofs(s_axi_araddr))
        SPC_OFS_CTRL: next_rdata[7:0] = serial_control;
        SPC_OFS_FORMAT: next_rdata[7:0] = serial_format;
        SPC_OFS_LINE: next_rdata[2:0] = serial_status;
        SPC_OFS_EVENT: begin
          next_rdata[3:0] = events;
          next_events = '0;
        end
        SPC_OFS_MASK: next_rdata[3:0] = mask;
        default: next_rresp = SPC_RESP_SLVERR;
      endcase
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = SPC_RESP_OKAY;
      unique case (spc_ofs(aw_addr))
        SPC_OFS_CTRL: if (w_lane) next_control = w_data;
        SPC_OFS_FORMAT: if (w_lane) next_format = w_data;
        // Writing 0 clears a line flag; writing 1 leaves it.
        SPC_OFS_LINE: if (w_lane) next_status = serial_status & w_data[2:0];
        SPC_OFS_EVENT: begin
        end
        SPC_OFS_MASK: if (w_lane) next_mask = w_data[3:0];
        default: next_bresp = SPC_RESP_SLVERR;
      endcase
    end
    if (rx_release) begin
      next_control[SPC_B_FILTER] = 1'b0;
    end
    // Flags are set after any clear so that a same-cycle event wins.
    if (rx_ok) begin
      if (!rx_char_frame_err) next_status[SPC_B_RX_FULL] = 1'b1;
      if (rx_char_frame_err) next_status[SPC_B_FRAME_ERR] = 1'b1;
      if (rx_char_overrun) next_status[SPC_B_OVERRUN] = 1'b1;
      if (!rx_char_frame_err) next_events[SPC_E_RX] = 1'b1;
      if (rx_char_frame_err || rx_char_overrun) next_events[SPC_E_ERR] = 1'b1;
    end
    if (tx_done && !tx_done_q) next_events[SPC_E_TX_DONE] = 1'b1;
    if (rx_release) next_events[SPC_E_MATCH] = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= SPC_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= SPC_RESP_OKAY;
      rdata <= 32'h0000_0000;
      serial_control <= SPC_RST_CTRL;
      serial_format <= SPC_RST_FORMAT;
      serial_status <= 3'h0;
      events <= 4'h0;
      mask <= SPC_RST_MASK;
      accept_q <= 1'b0;
      tx_done_q <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane <= next_w_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      serial_control <= next_control;
      serial_format <= next_format;
      serial_status <= next_status;
      events <= next_events;
      mask <= next_mask;
      accept_q <= next_accept_q;
      tx_done_q <= next_tx_done_q;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_tx_empty_gate: assert property (tx_empty_irq |-> serial_control[SPC_B_TX_EMPTY_IE] && tx_empty)
    else $error("transmit-empty request without enable");
  a_rx_irq_mask: assert property (!serial_control[SPC_B_RX_IE] |-> !rx_full_irq && !rx_error_irq)
    else $error("receive request while receive interrupts masked");
  a_tx_run_gate: assert property (tx_run == serial_control[SPC_B_TX_EN])
    else $error("transmitter running against enable");
  a_rx_off_accept: assert property (!rx_run |=> !rx_char_accept)
    else $error("character accepted while receiver disabled");
  a_filter_mode: assert property (serial_format[SPC_B_SYNC] && rx_char_valid && rx_run
    && !rx_char_mpb && !rx_char_frame_err |=> rx_char_accept)
    else $error("filter acted in clocked synchronous mode");
  a_filter_drop: assert property (rx_char_valid && rx_run && filter_active && !rx_char_mpb
    |=> !rx_char_accept && $stable(serial_status))
    else $error("filtered character handed on or flagged");
  a_filter_flags: assert property (filter_active && !rx_char_mpb && !(do_write
    && spc_ofs(aw_addr) == SPC_OFS_LINE) |=> !$rose(serial_status[SPC_B_RX_FULL]))
    else $error("receive-full set while filtering");
  a_filter_release: assert property (rx_char_valid && rx_run && filter_active && rx_char_mpb
    && !rx_char_frame_err |=> !serial_control[SPC_B_FILTER] && rx_char_accept
    && serial_status[SPC_B_RX_FULL])
    else $error("marked character did not release filter");
  a_tx_done_gate: assert property (!serial_control[SPC_B_TX_DONE_IE] |-> !tx_done_irq)
    else $error("transmit-done request without enable");
  a_async_clk_out: assert property (!sync_mode && cif.sel == SPC_CLK_INT_OUT
    |-> serial_clk_pin_oe)
    else $error("bit clock not driven in async code 01");
  a_sync_clk_out: assert property (sync_mode && cif.sel == SPC_CLK_INT |-> serial_clk_pin_oe)
    else $error("clock not driven in clocked synchronous code 00");
  // Bus answers and sticky events must hold until they are consumed.
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before it was taken");
  a_write_unmapped: assert property (do_write && spc_ofs(aw_addr) > SPC_OFS_MASK
    |=> s_axi_bresp == SPC_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_drop_no_event: assert property (rx_drop |=> !$rose(events[SPC_E_RX]))
    else $error("filtered character raised a receive event");
  a_release_event: assert property (rx_release |=> events[SPC_E_MATCH])
    else $error("filter release did not raise its event");
  a_match_sticky: assert property (events[SPC_E_MATCH] && !do_read |=> events[SPC_E_MATCH])
    else $error("release event lost without a read");
endmodule
`default_nettype wire

// >>> spc_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module spc_far_end (
  input wire logic clk,
  input wire logic ext_on,
  output logic rx_char_valid,
  output logic rx_char_mpb,
  output logic rx_char_frame_err,
  output logic rx_char_overrun,
  output logic tx_empty,
  output logic tx_done,
  output logic pin_drv
);
  logic [1:0] ph = 2'h0;

  initial begin
    rx_char_valid = 1'b0;
    rx_char_mpb = 1'b0;
    rx_char_frame_err = 1'b0;
    rx_char_overrun = 1'b0;
    tx_empty = 1'b0;
    tx_done = 1'b0;
    pin_drv = 1'b1;
  end

  // ==========================================================
  // Clock source
  // The pin rests high when unused and runs at a quarter of clk under ext_on.
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    pin_drv <= ext_on ? ph[1] : 1'b1;
  end

  // ==========================================================
  // Character and transmitter status
  // Qualifiers flip after the pulse so that stale values are never seen.
  task automatic send(input logic m, input logic f, input logic o);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char_mpb <= m;
    rx_char_frame_err <= f;
    rx_char_overrun <= o;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char_mpb <= ~m;
    rx_char_frame_err <= ~f;
    rx_char_overrun <= ~o;
  endtask

  task automatic set_tx(input logic e, input logic d);
    @(posedge clk);
    tx_empty <= e;
    tx_done <= d;
  endtask
endmodule
`default_nettype wire

// >>> serial_port_control_reg_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_control_reg_tb;
  import spc_pkg::*;
  localparam logic [7:0] ctl_a = SPC_OFS_CTRL;
  localparam logic [7:0] fmt_a = SPC_OFS_FORMAT;
  localparam logic [7:0] line_a = SPC_OFS_LINE;
  localparam logic [7:0] evt_a = SPC_OFS_EVENT;
  localparam logic [7:0] msk_a = SPC_OFS_MASK;
  localparam logic [1:0] ok = SPC_RESP_OKAY;
  localparam logic [1:0] er = SPC_RESP_SLVERR;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, baud_half_tick = 1'b0, ext_on = 1'b0;
  logic rx_char_valid, rx_char_mpb, rx_char_frame_err, rx_char_overrun, tx_empty, tx_done;
  logic pin_drv, serial_clk_pin_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic s_axi_rvalid, serial_clk_pin_o, serial_clk_pin_oe, bit_tick, ext_clk_sel, tx_run;
  logic rx_run, rx_char_accept, sync_mode, char7, parity_en, parity_odd, two_stop;
  logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
  logic last_o = 1'b1, last_i = 1'b1;
  logic [7:0] lfsr_q = 8'h5f;
  logic [7:0] v;
  logic [7:0] cv [4] = '{8'h84, 8'h80, 8'h04, 8'h30};
  logic [7:0] fm [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
  logic [7:0] cc [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h02};
  logic [4:0] eo = 5'b01010;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, n_tests = 0, cyc = 0, bcnt = 0, a0, t0, g0, h0, r0;
  int n_tick = 0, n_tog = 0, n_rise = 0, n_acc = 0, n_half = 0;

  // The wire level comes from whichever side is driving the pin.
  assign serial_clk_pin_i = serial_clk_pin_oe ? serial_clk_pin_o : pin_drv;

  spc_serial_control dut (.*);
  spc_far_end far (.*);

  always #2 clk = ~clk;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    return lfsr_q;
  endfunction

  function automatic logic near(input int a, input int b);
    return (a >= b - 1) && (a <= b + 1) && (b > 0);
  endfunction

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rnd(), rnd(), rnd(), d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
    do begin
      @(negedge clk);
      tb = s_axi_bvalid;
      @(posedge clk);
    end while (!tb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    logic t;
    @(posedge clk);
    rq.push_back({r, 24'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      @(posedge clk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================
  // Baud ticks, timeout and output watcher
  always @(posedge clk) begin
    bcnt <= (bcnt + 1) % 4;
    baud_half_tick <= (bcnt == 3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
    n_tick <= n_tick + int'(bit_tick);
    n_half <= n_half + int'(baud_half_tick);
    n_acc <= n_acc + int'(rx_char_accept);
    n_tog <= n_tog + int'(serial_clk_pin_o != last_o);
    n_rise <= n_rise + int'(serial_clk_pin_i && !last_i);
    last_o <= serial_clk_pin_o;
    last_i <= serial_clk_pin_i;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk("pin_oe", 34'h0, 34'(serial_clk_pin_oe));
    rd(ctl_a, SPC_RST_CTRL, ok);
    s_axi_wstrb <= 4'he;
    wr(ctl_a, 8'hff, ok);
    s_axi_wstrb <= 4'hf;
    rd(ctl_a, 8'h00, ok);
    rd(fmt_a, SPC_RST_FORMAT, ok);
    rd(msk_a, {4'h0, SPC_RST_MASK}, ok);
    rd(8'h14, 8'h00, er);
    wr(8'h14, 8'hff, er);
    for (int i = 0; i < 4; i++) begin
      v = rnd() & 8'h7f;
      wr(fmt_a, v, ok);
      rd(fmt_a, v, ok);
      settle();
      chk("parity_en", 34'(v[5] & ~v[2]), 34'(parity_en));
      chk("parity_odd", 34'(v[4] & v[5] & ~v[2]), 34'(parity_odd));
      chk("sync_mode", 34'h0, 34'(sync_mode));
      chk("char7", 34'(v[6]), 34'(char7));
      chk("two_stop", 34'(v[3]), 34'(two_stop));
    end
    wr(fmt_a, 8'h00, ok);
    wr(ctl_a, 8'h40, ok);
    a0 = n_acc;
    far.send(1'b0, 1'b0, 1'b0);
    settle();
    chk("accept", 34'(a0), 34'(n_acc));
    chk("rx_full_irq", 34'h0, 34'(rx_full_irq));
    wr(ctl_a, 8'h10, ok);
    far.send(1'b0, 1'b0, 1'b0);
    settle();
    chk("accept", 34'(a0 + 1), 34'(n_acc));
    chk("rx_full_irq", 34'h0, 34'(rx_full_irq));
    wr(ctl_a, 8'h50, ok);
    settle();
    chk("rx_full_irq", 34'h1, 34'(rx_full_irq));
    far.send(1'b0, 1'b1, 1'b1);
    settle();
    chk("rx_error_irq", 34'h1, 34'(rx_error_irq));
    rd(line_a, 8'h07, ok);
    wr(ctl_a, 8'h10, ok);
    settle();
    chk("rx_error_irq", 34'h0, 34'(rx_error_irq));
    chk("rx_full_irq", 34'h0, 34'(rx_full_irq));
    rd(evt_a, 8'h03, ok);
    wr(msk_a, 8'h01, ok);
    far.send(1'b0, 1'b0, 1'b0);
    settle();
    chk("irq", 34'h1, 34'(irq));
    rd(evt_a, 8'h01, ok);
    settle();
    chk("irq", 34'h0, 34'(irq));
    wr(msk_a, 8'h00, ok);
    far.send(1'b0, 1'b0, 1'b0);
    settle();
    chk("irq", 34'h0, 34'(irq));
    rd(evt_a, 8'h01, ok);
    wr(line_a, 8'h00, ok);
    wr(fmt_a, 8'h04, ok);
    wr(ctl_a, 8'h58, ok);
    a0 = n_acc;
    far.send(1'b0, 1'b0, 1'b0);
    far.send(1'b0, 1'b1, 1'b1);
    settle();
    chk("accept", 34'(a0), 34'(n_acc));
    rd(line_a, 8'h00, ok);
    rd(ctl_a, 8'h58, ok);
    far.send(1'b1, 1'b0, 1'b0);
    settle();
    chk("accept", 34'(a0 + 1), 34'(n_acc));
    chk("rx_full_irq", 34'h1, 34'(rx_full_irq));
    rd(ctl_a, 8'h50, ok);
    rd(evt_a, 8'h09, ok);
    for (int i = 0; i < 2; i++) begin
      wr(line_a, 8'h00, ok);
      wr(fmt_a, i ? 8'h84 : 8'h00, ok);
      wr(ctl_a, 8'h58, ok);
      a0 = n_acc;
      far.send(1'b0, 1'b0, 1'b0);
      settle();
      chk("accept", 34'(a0 + 1), 34'(n_acc));
    end
    wr(fmt_a, 8'h00, ok);
    far.set_tx(1'b1, 1'b1);
    foreach (cv[i]) begin
      wr(ctl_a, cv[i], ok);
      rd(ctl_a, cv[i], ok);
      settle();
      chk("tx_empty_irq", 34'(cv[i][7]), 34'(tx_empty_irq));
      chk("tx_done_irq", 34'(cv[i][2]), 34'(tx_done_irq));
      chk("tx_run", 34'(cv[i][5]), 34'(tx_run));
      chk("rx_run", 34'(cv[i][4]), 34'(rx_run));
    end
    rd(evt_a, 8'h05, ok);
    for (int i = 0; i < 5; i++) begin // Only defined codes are written.
      wr(fmt_a, fm[i], ok);
      wr(ctl_a, cc[i], ok);
      @(posedge clk);
      ext_on <= cc[i][1];
      repeat (8) @(posedge clk);
      t0 = n_tick;
      g0 = n_tog;
      h0 = n_half;
      r0 = n_rise;
      repeat (256) @(posedge clk);
      @(negedge clk);
      chk("pin_oe", 34'(eo[i]), 34'(serial_clk_pin_oe));
      chk("ext_clk_sel", 34'(cc[i][1]), 34'(ext_clk_sel));
      if (i == 0 || i == 3) chk("bit_tick", 34'h1, 34'(near(n_tick - t0, (n_half - h0) / 2)));
      if (i == 1) chk("pin_toggles", 34'h1, 34'(near(n_tog - g0, n_half - h0)));
      if (i == 2) chk("bit_tick", 34'h1, 34'(near(n_tick - t0, (n_rise - r0) / 16)));
      if (i == 4) chk("bit_tick", 34'h1, 34'(near(n_tick - t0, n_rise - r0)));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
